// ==== shared/fcld_cfg.svh ====
// Purpose: Constants for the fault code latch and display block
// Assumes: 50 MHz mclk
// Notes:   Codes are two BCD digits, tens digit in the high nibble
`ifndef FCLD_CFG_SVH
`define FCLD_CFG_SVH

// ----------------------------------------
// Display codes
// ----------------------------------------
`define FCLD_VERSION_CODE   8'h40
`define FCLD_MARKER_CODE    8'hf1
`define FCLD_BLANK_CODE     8'h00

// ----------------------------------------
// Fault numbers
// ----------------------------------------
`define FCLD_CODE_PHSEQ     8'h01
`define FCLD_CODE_PHMISS0   8'h02
`define FCLD_CODE_UNDERV0   8'h05
`define FCLD_CODE_INTERN0   8'h31
`define FCLD_CODE_LOWDC     8'h43
`define FCLD_CODE_EARTH     8'h44
`define FCLD_CODE_MSWBAD    8'h45
`define FCLD_CODE_UNBAL     8'h46
`define FCLD_CODE_TEMPMEAS  8'h47
`define FCLD_CODE_UNCTRL    8'h48
`define FCLD_CODE_LOOPBRK   8'h49
`define FCLD_CODE_LOAD      8'h72

// ----------------------------------------
// Timing
// ----------------------------------------
`define FCLD_PHASE_MS       500
`define FCLD_CLK_KHZ        50000
`define FCLD_PHASE_CYC      (`FCLD_PHASE_MS * `FCLD_CLK_KHZ)

`endif

// ==== shared/fcld_pkg.sv ====
// Purpose: Types shared by the fault code latch and display block
// Assumes: fcld_cfg.svh supplies numbers
// Notes:   One bit per fault source in the vector
package fcld_pkg;

  // ----------------------------------------
  // Fault source vector
  // ----------------------------------------
  typedef struct packed {
    logic       load;       // Load related, master switch clears
    logic       loop_brk;   // Load cell loop broken
    logic       unctrl;     // Stopped by itself
    logic       temp_meas;  // Thyristor temperature measurement
    logic       unbal;      // Parallel bridge unbalance
    logic       low_dc;     // Control supply too low
    logic       earth;      // Control supply earth fault
    logic [6:0] intern;     // Codes 31..37
    logic [2:0] underv;     // Codes 05..07
    logic [2:0] ph_miss;    // Codes 02..04
    logic       ph_seq;     // Code 01
  } fcld_fault_type;

  // ----------------------------------------
  // Operator and power sequencing inputs
  // ----------------------------------------
  typedef struct packed {
    logic master_zero;     // Master switch in neutral
    logic master_dir_a;
    logic master_dir_b;
    logic reset_pb;
    logic crane_on;        // Main on
    logic ctrl_volt;       // Control voltage present
  } fcld_oper_type;

  typedef enum logic [1:0] {
    FCLD_SHOW_VER    = 2'b00,
    FCLD_SHOW_MARKER = 2'b01,
    FCLD_SHOW_CODE   = 2'b10
  } fcld_show_type;

endpackage

// ==== src/fcld_sync.sv ====
// Purpose: Two flip-flop synchroniser for a vector of pin levels
// Assumes: Inputs asynchronous to mclk
// Notes:   First stage read only by the second
`timescale 1ns/1ps
module fcld_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_r;

  // ----------------------------------------
  // Two stage chain
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule

// ==== src/fcld_prio.sv ====
// Purpose: Pick one latched fault and give its two digit code
// Assumes: Latched vector from the main block
// Notes:   Lowest code number wins
`timescale 1ns/1ps
`include "fcld_cfg.svh"
module fcld_prio (
  input  wire fcld_pkg::fcld_fault_type latched,
  output logic                          any,
  output logic [7:0]                    code
);

  // Index of the lowest set bit within a small group
  function automatic logic [7:0] first_idx(input logic [6:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 6; i >= 0; i--) begin
      if (v[i]) begin
        r = 8'(i);
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // Fixed priority encode
  // ----------------------------------------
  assign any = |latched;

  always_comb begin
    code = `FCLD_BLANK_CODE;
    if (latched.ph_seq)          code = `FCLD_CODE_PHSEQ;
    else if (|latched.ph_miss)   code = `FCLD_CODE_PHMISS0 + first_idx({4'h0, latched.ph_miss});
    else if (|latched.underv)    code = `FCLD_CODE_UNDERV0 + first_idx({4'h0, latched.underv});
    else if (|latched.intern)    code = `FCLD_CODE_INTERN0 + first_idx(latched.intern);
    else if (latched.low_dc)     code = `FCLD_CODE_LOWDC;
    else if (latched.earth)      code = `FCLD_CODE_EARTH;
    else if (latched.unbal)      code = `FCLD_CODE_UNBAL;
    else if (latched.temp_meas)  code = `FCLD_CODE_TEMPMEAS;
    else if (latched.unctrl)     code = `FCLD_CODE_UNCTRL;
    else if (latched.loop_brk)   code = `FCLD_CODE_LOOPBRK;
    else if (latched.load)       code = `FCLD_CODE_LOAD;
  end

endmodule

// ==== src/fcld_top.sv ====
// Purpose: Fault code latch, two digit display and motion start gate
// Assumes: Fault detectors and operator pins are asynchronous
// Notes:   Display toggles marker and code every phase period
//          Reset press never clears the off-class faults; only a crane
//          switch-off or switch-on does, so the button is harmless there
//          Code 48 outlives both and goes only with the control voltage
//          Only one code shows at a time; the others wait until it clears
//
// What this block does
// - With no fault latched the display shows version code 40.
// - With a fault latched the display alternates the marker and the code.
// - Load related faults clear when the master switch is back in neutral.
// - Other faults stay until reset pushbutton or crane switch-on.
// - For most codes the reset pushbutton is ignored until the crane is switched off.
// - One reset press clears every non-persistent fault together.
// - The code stays after a motion off-on sequence until a reset.
// - Motion may start only after the zero-position signal.
// - Code 01 stops motion and clears only at switch-off or switch-on.
// - Codes 02 to 07 stop motion and clear only at switch-off or switch-on.
// - Codes 31 to 37 stop motion and clear only at switch-off or switch-on.
// - Code 44 takes no motion action and clears by switch-off or reset.
// - Code 45 flags an impossible master switch combination, stops, clears at switch-off.
// - Code 47 does not stop motion and clears by switch-off or reset.
// - Code 48 flags an uncommanded stop and clears only with control voltage removal.
// - Code 49 takes no motion action and clears by switch-off or reset.
`timescale 1ns/1ps
`include "fcld_cfg.svh"
module fcld_top #(
  parameter int PHASE_CYC = `FCLD_PHASE_CYC
) (
  input  wire logic                     mclk,
  input  wire logic                     srst,
  input  wire fcld_pkg::fcld_fault_type fault_in,
  input  wire logic                     msw_bad_in,
  input  wire fcld_pkg::fcld_oper_type  oper_in,
  input  wire logic                     run_cmd,
  input  wire logic                     motion_running,
  output logic [7:0]                    disp_code,
  output logic                          fault_active,
  output logic                          motion_enable,
  output logic                          motion_stop
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Every pin is asynchronous; two stages cost two cycles of latency
  // that a half-second display phase never shows
  localparam int FW = $bits(fcld_pkg::fcld_fault_type);
  localparam int OW = $bits(fcld_pkg::fcld_oper_type);

  logic [FW-1:0]            fault_s;
  logic [OW-1:0]            oper_s;
  logic [2:0]               misc_s;
  fcld_pkg::fcld_fault_type flt;
  fcld_pkg::fcld_oper_type  op;

  fcld_sync #(.WIDTH(FW)) u_sync_flt (
    .mclk (mclk),
    .srst (srst),
    .din  (fault_in),
    .dout (fault_s)
  );

  fcld_sync #(.WIDTH(OW)) u_sync_op (
    .mclk (mclk),
    .srst (srst),
    .din  (oper_in),
    .dout (oper_s)
  );

  fcld_sync #(.WIDTH(3)) u_sync_misc (
    .mclk (mclk),
    .srst (srst),
    .din  ({msw_bad_in, run_cmd, motion_running}),
    .dout (misc_s)
  );

  assign flt = fcld_pkg::fcld_fault_type'(fault_s);
  assign op  = fcld_pkg::fcld_oper_type'(oper_s);

  // ----------------------------------------
  // Edge helpers
  // ----------------------------------------
  // Level now high that was low one edge ago
  function automatic logic rise_of(input logic now_v, input logic was_v);
    return now_v & ~was_v;
  endfunction

  // Level now low that was high one edge ago
  function automatic logic fall_of(input logic now_v, input logic was_v);
    return ~now_v & was_v;
  endfunction

  // ----------------------------------------
  // Edge and event decode
  // ----------------------------------------
  logic on_r;
  logic rst_pb_r;
  logic run_r;
  logic cv_r;
  logic switch_on;
  logic switch_off;
  logic reset_press;
  logic cv_removed;
  logic msw_bad;
  logic run_s;
  logic running_s;
  logic uncmd_stop;

  assign msw_bad     = misc_s[2] | (op.master_zero & (op.master_dir_a | op.master_dir_b))
                     | (op.master_dir_a & op.master_dir_b);
  assign run_s       = misc_s[1];
  assign running_s   = misc_s[0];
  // Pin level edges; a held button counts once
  assign switch_on   = rise_of(op.crane_on, on_r);
  assign switch_off  = fall_of(op.crane_on, on_r);
  assign reset_press = rise_of(op.reset_pb, rst_pb_r);
  assign cv_removed  = fall_of(op.ctrl_volt, cv_r);
  // Running dropped while still commanded: stopped by itself
  assign uncmd_stop  = run_r & ~running_s & run_s & op.crane_on;

  // Edge history
  // A crane already on at reset reads as a switch-on; nothing is latched then
  always_ff @(posedge mclk) begin
    if (srst) begin
      on_r     <= 1'b0;
      rst_pb_r <= 1'b0;
      run_r    <= 1'b0;
      cv_r     <= 1'b0;
    end else begin
      on_r     <= op.crane_on;
      rst_pb_r <= op.reset_pb;
      run_r    <= running_s;
      cv_r     <= op.ctrl_volt;
    end
  end

  // ----------------------------------------
  // Fault latch with per-class clearing
  // ----------------------------------------
  fcld_pkg::fcld_fault_type lat_r;
  fcld_pkg::fcld_fault_type lat_nxt;
  logic                     msw_lat_r;
  logic                     msw_lat_nxt;
  logic                     clr_off;
  logic                     clr_resettable;
  logic                     clr_load;

  // Off-only faults: switch-off clears; reset press is ignored for them
  assign clr_off        = switch_off | switch_on;
  // Resettable class clears on reset press or at switch on/off
  assign clr_resettable = clr_off | reset_press;
  // Level, not edge: a load fault raised while in neutral still latches, then clears once it drops
  assign clr_load       = op.master_zero;

  // Set wins over clear so a same-cycle event is never lost
  always_comb begin
    lat_nxt = lat_r;
    if (clr_off) begin
      lat_nxt.ph_seq  = 1'b0;
      lat_nxt.ph_miss = '0;
      lat_nxt.underv  = '0;
      lat_nxt.intern  = '0;
      lat_nxt.low_dc  = 1'b0;
      lat_nxt.unbal   = 1'b0;
    end
    if (clr_resettable) begin
      lat_nxt.earth     = 1'b0;
      lat_nxt.temp_meas = 1'b0;
      lat_nxt.loop_brk  = 1'b0;
    end
    if (clr_load) begin
      lat_nxt.load = 1'b0;
    end
    if (cv_removed) begin
      lat_nxt.unctrl = 1'b0;
    end
    lat_nxt        = fcld_pkg::fcld_fault_type'(lat_nxt | flt);
    lat_nxt.unctrl = lat_nxt.unctrl | uncmd_stop;
  end

  // Code 45 clears only at switch-off or switch-on
  // Level input: a report that persists latches again at once after a clear
  assign msw_lat_nxt = (msw_lat_r & ~clr_off) | msw_bad;

  always_ff @(posedge mclk) begin
    if (srst) begin
      lat_r     <= '0;
      msw_lat_r <= 1'b0;
    end else begin
      lat_r     <= lat_nxt;
      msw_lat_r <= msw_lat_nxt;
    end
  end

  // ----------------------------------------
  // Motion stop decision
  // ----------------------------------------
  logic stop_class;
  logic stop_line;
  logic stop_ctrl;
  logic stop_oper;

  // Supply side faults, codes 01 to 07
  assign stop_line  = lat_r.ph_seq | (|lat_r.ph_miss) | (|lat_r.underv);
  // Controller side faults, codes 31 to 37, 43 and 46
  assign stop_ctrl  = (|lat_r.intern) | lat_r.low_dc | lat_r.unbal;
  // Operator side: bad switch, uncommanded stop and load class
  assign stop_oper  = msw_lat_r | lat_r.unctrl | lat_r.load;
  // Codes 44, 47, 49 are left out on purpose: they take no motion action
  assign stop_class = stop_line | stop_ctrl | stop_oper;

  // ----------------------------------------
  // Zero position start gate
  // ----------------------------------------
  logic zero_seen_r;
  logic zero_seen_nxt;

  logic run_dropped;
  logic zero_arm;
  logic zero_keep;

  // Any stop, commanded or not, means the next start needs a fresh neutral
  assign run_dropped   = run_r & ~running_s;
  // Arm on neutral; a stop-class fault or crane off disarms
  assign zero_arm      = op.master_zero & ~stop_class & op.crane_on;
  assign zero_keep     = zero_seen_r & ~stop_class & op.crane_on & ~run_dropped;
  assign zero_seen_nxt = zero_arm | zero_keep;

  always_ff @(posedge mclk) begin
    if (srst) begin
      zero_seen_r <= 1'b0;
    end else begin
      zero_seen_r <= zero_seen_nxt;
    end
  end

  // ----------------------------------------
  // Priority pick and code for display
  // ----------------------------------------
  logic       prio_any;
  logic [7:0] prio_code;
  logic       any_fault;
  logic [7:0] show_code;
  logic       msw_first;

  fcld_prio u_prio (
    .latched (lat_r),
    .any     (prio_any),
    .code    (prio_code)
  );

  // Code 45 ranks just after code 44
  assign any_fault = prio_any | msw_lat_r;
  assign msw_first = msw_lat_r & ((prio_code > `FCLD_CODE_EARTH) | ~prio_any);
  assign show_code = msw_first ? `FCLD_CODE_MSWBAD : prio_code;

  // ----------------------------------------
  // Display phase timer
  // ----------------------------------------
  localparam int CW = $clog2(PHASE_CYC + 1);

  logic [CW-1:0]           tmr_r;
  logic                    tmr_done;
  logic                    tmr_clr;
  fcld_pkg::fcld_show_type show_r;
  fcld_pkg::fcld_show_type show_nxt;

  assign tmr_done = (tmr_r == CW'(PHASE_CYC - 1));
  // Idle timer sits at zero so each new fault starts its marker phase afresh
  assign tmr_clr  = srst | ~any_fault | tmr_done;

  // Phase counter
  always_ff @(posedge mclk) begin
    if (tmr_clr) begin
      tmr_r <= '0;
    end else begin
      tmr_r <= tmr_r + CW'(1);
    end
  end

  // Marker and code alternate while a fault is held
  always_comb begin
    show_nxt = show_r;
    unique case (show_r)
      fcld_pkg::FCLD_SHOW_VER: begin
        if (any_fault) show_nxt = fcld_pkg::FCLD_SHOW_MARKER;
      end
      fcld_pkg::FCLD_SHOW_MARKER: begin
        if (~any_fault)    show_nxt = fcld_pkg::FCLD_SHOW_VER;
        else if (tmr_done) show_nxt = fcld_pkg::FCLD_SHOW_CODE;
      end
      fcld_pkg::FCLD_SHOW_CODE: begin
        if (~any_fault)    show_nxt = fcld_pkg::FCLD_SHOW_VER;
        else if (tmr_done) show_nxt = fcld_pkg::FCLD_SHOW_MARKER;
      end
      default: show_nxt = fcld_pkg::FCLD_SHOW_VER;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      show_r <= fcld_pkg::FCLD_SHOW_VER;
    end else begin
      show_r <= show_nxt;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  logic [7:0] disp_nxt;
  logic       fault_active_nxt;
  logic       motion_stop_nxt;

  assign disp_nxt = (show_nxt == fcld_pkg::FCLD_SHOW_MARKER) ? `FCLD_MARKER_CODE
                  : (show_nxt == fcld_pkg::FCLD_SHOW_CODE)   ? show_code
                  : `FCLD_VERSION_CODE;

  // Stop follows the latched class, in step with the start gate that it blocks
  assign fault_active_nxt = any_fault;
  assign motion_stop_nxt  = stop_class;

  always_ff @(posedge mclk) begin
    if (srst) begin
      disp_code     <= `FCLD_VERSION_CODE;
      fault_active  <= 1'b0;
      motion_enable <= 1'b0;
      motion_stop   <= 1'b0;
    end else begin
      disp_code     <= disp_nxt;
      fault_active  <= fault_active_nxt;
      motion_enable <= zero_seen_nxt;
      motion_stop   <= motion_stop_nxt;
    end
  end

endmodule

// ==== bench/fcld_chk_sva.sv ====
// Purpose: Port checker for the fault latch and display block
// Assumes: Bound to fcld_top, one clock domain
// Notes:   Pins pass two sync stages, so causes may take up to six edges
`timescale 1ns/1ps
module fcld_chk #(
  parameter int PHASE_CYC = 8
) (
  input wire logic                     mclk,
  input wire logic                     srst,
  input wire fcld_pkg::fcld_fault_type fault_in,
  input wire logic                     msw_bad_in,
  input wire fcld_pkg::fcld_oper_type  oper_in,
  input wire logic [7:0]               disp_code,
  input wire logic                     fault_active,
  input wire logic                     motion_enable,
  input wire logic                     motion_stop
);
  logic [7:0]  disp_r;
  logic [31:0] stand_r;
  logic        zero_seen_r;

  default clocking @(posedge mclk); endclocking
  default disable iff (srst);

  // Cycles the display has held one value; a stuck display overflows it
  always_ff @(posedge mclk) begin
    disp_r  <= disp_code;
    stand_r <= (srst || !fault_active || disp_code != disp_r) ? 32'h0 : stand_r + 32'h1;
  end

  // Neutral seen since the crane came on; pin level, so ahead of the design
  always_ff @(posedge mclk) begin
    if (srst || !oper_in.crane_on) begin
      zero_seen_r <= 1'h0;
    end else if (oper_in.master_zero) begin
      zero_seen_r <= 1'h1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_VERSION: assert property (!fault_active [*2] |-> disp_code == 8'h40)
    else $error("version not shown while idle");
  AST_MARKER_FIRST: assert property ($rose(fault_active) |-> disp_code == 8'hf1)
    else $error("marker not shown on new fault");
  AST_PHASE_LEN: assert property (stand_r <= PHASE_CYC)
    else $error("display phase held too long");
  AST_LATCH_TIME: assert property ($rose(|fault_in) |-> ##[2:6] fault_active)
    else $error("fault not latched in time");
  AST_PHSEQ_STOP: assert property ($rose(fault_in.ph_seq) |-> ##[2:6] motion_stop)
    else $error("phase order fault did not stop");
  AST_LINE_STOP: assert property ($rose(|{fault_in.ph_miss, fault_in.underv}) |-> ##[2:6] motion_stop)
    else $error("line fault did not stop");
  AST_INTERN_STOP: assert property ($rose(|fault_in.intern) |-> ##[2:6] motion_stop)
    else $error("internal fault did not stop");
  AST_MSW_STOP: assert property ($rose(msw_bad_in) |-> ##[2:6] (motion_stop && fault_active))
    else $error("bad switch did not stop");
  AST_STOP_BLOCKS: assert property (motion_stop [*2] |-> !motion_enable)
    else $error("enabled while stopped");
  AST_OFF_BLOCKS: assert property (!oper_in.crane_on [*4] |-> !motion_enable)
    else $error("enabled while crane off");
  AST_ZERO_FIRST: assert property ($rose(motion_enable) |-> zero_seen_r)
    else $error("enabled without neutral");
  AST_PB_KEEPS_STOP: assert property (($rose(oper_in.reset_pb) && motion_stop) ##1 ($stable(oper_in.crane_on) && $stable(oper_in.ctrl_volt)) [*6] |-> motion_stop)
    else $error("button cleared a stop fault");

  // Main scenarios reached
  cover property ($fell(fault_active));
  cover property ($rose(motion_enable));
  cover property ($fell(motion_stop));
endmodule

// ==== bench/fcld_oper_model.sv ====
// Purpose: Operator model: master switch and reset pushbutton
// Assumes: Bench commands change on the falling edge
// Notes:   Never shows a direction together with neutral
`timescale 1ns/1ps
module fcld_oper_model (
  input  wire logic               mclk,
  input  wire logic               neutral,
  input  wire logic               press,
  input  wire logic               on,
  input  wire logic               cv,
  output fcld_pkg::fcld_oper_type oper
);
  logic [2:0] hold_r = 3'h0;

  // A hand holds the button for several cycles, never a one-cycle blip;
  // sampled on the rising edge so a falling-edge command is never raced
  always_ff @(posedge mclk) begin
    hold_r <= press ? 3'h4 : ((hold_r != 3'h0) ? hold_r - 3'h1 : 3'h0);
  end

  // Direction only away from neutral, so starts pass through zero
  assign oper = '{master_zero: neutral, master_dir_a: !neutral, master_dir_b: 1'h0,
                  reset_pb: hold_r != 3'h0, crane_on: on, ctrl_volt: cv};
endmodule

// ==== bench/tb.sv ====
// Purpose: Self-checking bench for the fault latch and display block
// Assumes: Display phase shortened to 8 cycles
// Notes:   Inputs change on the falling edge
`timescale 1ns/1ps
module tb;
  localparam int PH = 8;
  typedef struct packed {
    logic [20:0] f;
    logic [7:0]  code;
    logic        stop;
    logic        rclr;
  } fcld_row_type;
  logic                     mclk = 1'h0;
  logic                     srst = 1'h1;
  fcld_pkg::fcld_fault_type fault_in = '0;
  logic                     msw_bad_in = 1'h0;
  logic                     run_cmd = 1'h0;
  logic                     running = 1'h0;
  logic                     neutral = 1'h0;
  logic                     press = 1'h0;
  logic                     on = 1'h1;
  logic                     cv = 1'h1;
  fcld_pkg::fcld_oper_type  oper;
  logic [7:0]               disp_code;
  logic                     fault_active;
  logic                     motion_enable;
  logic                     motion_stop;
  logic                     hit;
  int                       num_errors = 0;
  int                       n_compared = 0;
  int                       cycles = 0;
  // Fault source, shown code, stop class, cleared by the button
  fcld_row_type             rows [10] = '{
    '{21'h000001, 8'h01, 1'h1, 1'h0}, '{21'h000008, 8'h04, 1'h1, 1'h0},
    '{21'h000010, 8'h05, 1'h1, 1'h0}, '{21'h000080, 8'h31, 1'h1, 1'h0},
    '{21'h002000, 8'h37, 1'h1, 1'h0}, '{21'h004000, 8'h44, 1'h0, 1'h1},
    '{21'h008000, 8'h43, 1'h1, 1'h0}, '{21'h010000, 8'h46, 1'h1, 1'h0},
    '{21'h020000, 8'h47, 1'h0, 1'h1}, '{21'h080000, 8'h49, 1'h0, 1'h1}};

  fcld_oper_model op (.mclk(mclk), .neutral(neutral), .press(press), .on(on), .cv(cv),
                      .oper(oper));
  fcld_top #(.PHASE_CYC(PH)) uut (.mclk(mclk), .srst(srst), .fault_in(fault_in),
    .msw_bad_in(msw_bad_in), .oper_in(oper), .run_cmd(run_cmd), .motion_running(running),
    .disp_code(disp_code), .fault_active(fault_active), .motion_enable(motion_enable),
    .motion_stop(motion_stop));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Two full display phases must show the code at least once
  task automatic scan(input logic [7:0] c);
    hit = 1'h0;
    repeat (2 * PH + 4) begin
      @(negedge mclk);
      if (disp_code === c) hit = 1'h1;
    end
  endtask
  // Switch off and on, then back through neutral to re-arm starts
  task automatic off_on();
    on = 1'h0;
    cyc(5);
    on = 1'h1;
    cyc(5);
    neutral = 1'h1;
    cyc(5);
    neutral = 1'h0;
  endtask
  task automatic push();
    press = 1'h1;
    cyc(1);
    press = 1'h0;
    cyc(8);
  endtask
  task automatic pulse(input logic [20:0] f);
    fault_in = f;
    cyc(4);
    fault_in = '0;
    cyc(2);
  endtask
  task automatic wrap_up();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    forever #10 mclk = ~mclk;
  end
  // Hang guard, well above the roughly 800 cycles needed
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    cyc(20);
    srst = 1'h0;
    cyc(1);
    check(disp_code, 8'h40);
    cyc(8);
    check(8'(motion_enable), 8'h0);
    neutral = 1'h1;
    cyc(6);
    neutral = 1'h0;
    check(8'(motion_enable), 8'h1);
    for (int i = 0; i < 10; i++) begin
      pulse(rows[i].f);
      check(8'(fault_active), 8'h1);
      check(8'(motion_stop), 8'(rows[i].stop));
      scan(rows[i].code);
      check(8'(hit), 8'h1);
      push();
      check(8'(fault_active), 8'(!rows[i].rclr));
      off_on();
      check(8'(fault_active), 8'h0);
      check(8'(motion_enable), 8'h1);
    end
    // Two faults together: only the lower code is shown
    pulse(21'h004001);
    scan(8'h44);
    check(8'(hit), 8'h0);
    scan(8'h01);
    check(8'(hit), 8'h1);
    off_on();
    // Load fault goes with the switch back in neutral
    pulse(21'h100000);
    check(8'(fault_active), 8'h1);
    scan(8'h72);
    check(8'(hit), 8'h1);
    neutral = 1'h1;
    cyc(6);
    neutral = 1'h0;
    check(8'(fault_active), 8'h0);
    // Code survives a motion off-on, then one press clears all three
    pulse(21'h0a4000);
    run_cmd = 1'h1;
    cyc(5);
    run_cmd = 1'h0;
    scan(8'h44);
    check(8'(hit), 8'h1);
    push();
    check(8'(fault_active), 8'h0);
    // Stop without command needs control voltage removal
    run_cmd = 1'h1;
    running = 1'h1;
    cyc(5);
    running = 1'h0;
    cyc(6);
    run_cmd = 1'h0;
    scan(8'h48);
    check(8'(hit), 8'h1);
    push();
    off_on();
    check(8'(fault_active), 8'h1);
    cv = 1'h0;
    cyc(5);
    cv = 1'h1;
    cyc(5);
    check(8'(fault_active), 8'h0);
    // Impossible switch report: stops, button ignored
    msw_bad_in = 1'h1;
    cyc(4);
    msw_bad_in = 1'h0;
    scan(8'h45);
    check(8'(hit), 8'h1);
    check(8'(motion_stop), 8'h1);
    push();
    check(8'(fault_active), 8'h1);
    off_on();
    check(8'(fault_active), 8'h0);
    wrap_up();
  end
endmodule

bind fcld_top fcld_chk #(.PHASE_CYC(PHASE_CYC)) u_chk (.mclk(mclk), .srst(srst),
  .fault_in(fault_in), .msw_bad_in(msw_bad_in), .oper_in(oper_in), .disp_code(disp_code),
  .fault_active(fault_active), .motion_enable(motion_enable), .motion_stop(motion_stop));
